/* verilog/ptm8_pkg.sv */
// Shared constants, types and helpers of the period match timer block
package ptm8_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_TMR = 3;
  localparam int NUM_CH = 3;
  localparam int DW = 8;
  localparam int CW = 7;
  localparam int AW = 8;
  localparam int BW = 32;
  localparam int SEL_W = 2;
  typedef logic [DW-1:0] ptm8_byte_t;
  typedef logic [SEL_W-1:0] ptm8_sel_t;

  // ************************************************************
  // Reset values and control fields
  // ************************************************************
  localparam logic [DW-1:0] COUNT_RST = 8'h00;
  localparam logic [DW-1:0] PERIOD_RST = 8'hFF;
  localparam logic [CW-1:0] CTRL_RST = 7'h00;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] COUNT_ONE = 8'h01;
  localparam int RUN_BIT = 2;
  localparam int PRE_LSB = 0;
  localparam int POST_LSB = 3;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LAST1 = 4'h0;
  localparam logic [3:0] PRE_LAST4 = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;

  // ************************************************************
  // Instruction rate divider
  // ************************************************************
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam logic [1:0] DIV_ONE = 2'h1;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [AW-1:0] TMR_STRIDE = 8'h10;
  localparam logic [AW-1:0] OFS_COUNT = 8'h00;
  localparam logic [AW-1:0] OFS_PERIOD = 8'h04;
  localparam logic [AW-1:0] OFS_CTRL = 8'h08;
  localparam logic [AW-1:0] OFS_FLAGS3 = 8'h30;
  localparam logic [AW-1:0] OFS_FLAGS5 = 8'h34;
  localparam logic [AW-1:0] OFS_EN3 = 8'h38;
  localparam logic [AW-1:0] OFS_EN5 = 8'h3C;
  localparam logic [AW-1:0] OFS_TSEL = 8'h40;
  localparam logic [DW-1:0] FLAGS3_MASK = 8'h08;
  localparam logic [DW-1:0] FLAGS5_MASK = 8'h18;
  localparam int FLAG_BIT_T4 = 3;
  localparam int FLAG_BIT_T6 = 3;
  localparam int FLAG_BIT_T8 = 4;
  localparam logic [5:0] TSEL_RST = 6'h00;

  function automatic logic [3:0] ptm8_pre_last(input logic [1:0] sel);
    if (sel[1]) begin
      return PRE_LAST16;
    end else if (sel == PRE_DIV4) begin
      return PRE_LAST4;
    end
    return PRE_LAST1;
  endfunction : ptm8_pre_last

  function automatic logic ptm8_hit(input logic [AW-1:0] addr, input int idx,
                                    input logic [AW-1:0] ofs);
    return addr == (TMR_STRIDE * 8'(idx)) + ofs;
  endfunction : ptm8_hit
endpackage : ptm8_pkg

/* verilog/ptm8_unit_if.sv */
// Signals between the register front end and one timer unit
`timescale 1ns/10ps
interface ptm8_unit_if;
  import ptm8_pkg::*;
  logic tick;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic [DW-1:0] wdata;
  logic [DW-1:0] count;
  logic [DW-1:0] period;
  logic [CW-1:0] ctrl;
  logic match;
  logic post;
  modport unit (input tick, input wr_count, input wr_period, input wr_ctrl,
                input wdata, output count, output period, output ctrl,
                output match, output post);
  modport host (output tick, output wr_count, output wr_period, output wr_ctrl,
                output wdata, input count, input period, input ctrl,
                input match, input post);
endinterface : ptm8_unit_if

/* verilog/ptm8_unit.sv */
// One 8-bit period timer with prescaler and postscaler
`timescale 1ns/10ps
module ptm8_unit (
  input logic clk,
  input logic resetn,
  ptm8_unit_if.unit u
);
  import ptm8_pkg::*;

  logic [DW-1:0] count_reg;
  logic [DW-1:0] period_reg;
  logic [CW-1:0] ctrl_reg;
  logic [3:0] pre_reg;
  logic [3:0] post_reg;
  logic match_reg;
  logic hit_reg;
  logic run;
  logic clear;
  logic inc;
  logic wrap;
  logic hit;
  logic [1:0] pre_sel;
  logic [3:0] post_sel;

  assign run = ctrl_reg[RUN_BIT];
  assign pre_sel = ctrl_reg[PRE_LSB +: 2];
  assign post_sel = ctrl_reg[POST_LSB +: 4];
  assign clear = u.wr_count | u.wr_ctrl;
  assign inc = u.tick & run & ~clear & (pre_reg == ptm8_pre_last(pre_sel)); // see (R02) see (R06)
  assign wrap = inc & (count_reg == period_reg); // see (R12)
  assign hit = post_reg == post_sel; // see (R14)

  // ************************************************************
  // Prescaler
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= NIB_ZERO; // see (R08)
    end else if (clear) begin
      pre_reg <= NIB_ZERO; // see (R08)
    end else if (u.tick && run) begin
      pre_reg <= (pre_reg == ptm8_pre_last(pre_sel)) ? NIB_ZERO : pre_reg + NIB_ONE; // see (R13)
    end
  end

  // ************************************************************
  // Counter, period and control
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= COUNT_RST; // see (R07)
    end else if (u.wr_count) begin
      count_reg <= u.wdata; // see (R01)
    end else if (inc) begin
      count_reg <= wrap ? BYTE_ZERO : count_reg + COUNT_ONE; // see (R12)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_reg <= PERIOD_RST; // see (R12)
    end else if (u.wr_period) begin
      period_reg <= u.wdata; // see (R01)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (u.wr_ctrl) begin
      ctrl_reg <= u.wdata[CW-1:0]; // see (R09)
    end
  end

  // ************************************************************
  // Postscaler
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      post_reg <= NIB_ZERO; // see (R08)
    end else if (clear) begin
      post_reg <= NIB_ZERO; // see (R08)
    end else if (wrap) begin
      post_reg <= hit ? NIB_ZERO : post_reg + NIB_ONE; // see (R16)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      match_reg <= wrap; // see (R15)
      hit_reg <= wrap & hit; // see (R03)
    end
  end

  assign u.count = count_reg;
  assign u.period = period_reg;
  assign u.ctrl = ctrl_reg;
  assign u.match = match_reg;
  assign u.post = hit_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_count_wrap: assert property (wrap |=> count_reg == BYTE_ZERO) // see (R12)
    else $error("counter did not return to zero after period match");
  chk_count_step: assert property (inc && !wrap |=> count_reg == $past(count_reg) + COUNT_ONE) // see (R12)
    else $error("counter did not step by one");
  chk_run_hold: assert property (!run && !u.wr_count |=> $stable(count_reg)) // see (R06)
    else $error("stopped timer changed its count");
  chk_ctrl_keep: assert property (u.wr_ctrl && !u.wr_count |=> $stable(count_reg)) // see (R09)
    else $error("control write disturbed the count");
  chk_scaler_clear: assert property (clear |=> pre_reg == NIB_ZERO && post_reg == NIB_ZERO) // see (R08)
    else $error("scalers not cleared by write");
  sequence s_div16_steady;
    inc && pre_sel[1] && !u.wr_ctrl;
  endsequence
  chk_pre_gap: assert property (s_div16_steady |=> !inc [*8]) // see (R13)
    else $error("divide by sixteen prescaler stepped too soon");
  chk_post_nth: assert property (wrap && hit && !clear |=> hit_reg && post_reg == NIB_ZERO) // see (R16)
    else $error("postscaler missed its nth match");
  chk_post_only: assert property (hit_reg |-> $past(post_reg) == $past(post_sel)) // see (R14)
    else $error("postscaler fired at the wrong match");
endmodule : ptm8_unit

/* verilog/ptm8_top.sv */
// Three 8-bit period timers behind an Avalon-MM register slave
// ************************************************************
// Functional notes
// (R01) Each timer has a readable, writable 8-bit counter and period register.
// (R02) Counter clocked at system clock over four through a 1, 4 or 16 prescaler.
// (R03) Each period match feeds a 4-bit postscaler, ratio one to sixteen.
// (R04) Postscaler output sets the timer flag in flag register three or five.
// (R05) Each timer flag is gated onto the interrupt by its enable bit.
// (R06) Clearing control bit 2 stops the timer from counting.
// (R07) Any device reset clears the counter to zero.
// (R08) Counter write, control write or reset clears prescaler and postscaler.
// (R09) A control write leaves the counter value unchanged.
// (R10) Each timer can serve as a PWM time base.
// (R11) Per-channel select bits choose which timer drives each PWM channel.
// (R12) Count from zero to period, then zero; period resets to all ones.
// (R13) Prescale code 00 is 1, 01 is 4, 1x is 16.
// (R14) Postscale ratio equals its four-bit code plus one.
// (R15) The PWM time base is taken before the postscaler.
// (R16) Flag set on every Nth match, postscaler restarts, software clears flag.
// ************************************************************
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module ptm8_top (
  input logic clk,
  input logic resetn,
  input logic [ptm8_pkg::AW-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [ptm8_pkg::BW-1:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [ptm8_pkg::BW-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic [ptm8_pkg::NUM_CH-1:0][ptm8_pkg::DW-1:0] pwm_count,
  output logic [ptm8_pkg::NUM_CH-1:0] pwm_match
);
  import ptm8_pkg::*;

  // ************************************************************
  // Instruction rate divider
  // ************************************************************
  logic [1:0] div_reg;
  logic tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= DIV_ZERO;
    end else begin
      div_reg <= div_reg + DIV_ONE;
    end
  end

  assign tick = div_reg == DIV_LAST; // see (R02)

  // ************************************************************
  // Bus handshake
  // ************************************************************
  logic ack_reg;
  logic req;
  logic wr_go;
  logic [BW-1:0] readdata_reg;
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] wbyte;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_go = avs_write & ack_reg & avs_byteenable[0];
  assign wbyte = avs_writedata[DW-1:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= '0;
    end else if (avs_read && !ack_reg) begin
      readdata_reg <= {{(BW-DW){1'b0}}, rd_mux};
    end
  end

  assign avs_readdata = readdata_reg;

  // ************************************************************
  // Timer units
  // ************************************************************
  logic [NUM_TMR-1:0][DW-1:0] t_count;
  logic [NUM_TMR-1:0][DW-1:0] t_period;
  logic [NUM_TMR-1:0][CW-1:0] t_ctrl;
  logic [NUM_TMR-1:0] t_match;
  logic [NUM_TMR-1:0] t_post;

  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    ptm8_unit_if ui ();
    assign ui.tick = tick;
    assign ui.wdata = wbyte;
    assign ui.wr_count = wr_go & ptm8_hit(avs_address, i, OFS_COUNT); // see (R01)
    assign ui.wr_period = wr_go & ptm8_hit(avs_address, i, OFS_PERIOD); // see (R01)
    assign ui.wr_ctrl = wr_go & ptm8_hit(avs_address, i, OFS_CTRL); // see (R06)
    ptm8_unit u_unit (
      .clk(clk),
      .resetn(resetn),
      .u(ui.unit)
    );
    assign t_count[i] = ui.count;
    assign t_period[i] = ui.period;
    assign t_ctrl[i] = ui.ctrl;
    assign t_match[i] = ui.match;
    assign t_post[i] = ui.post;
  end

  // ************************************************************
  // Interrupt flags and enables
  // ************************************************************
  logic [DW-1:0] flags3_reg;
  logic [DW-1:0] flags5_reg;
  logic [DW-1:0] en3_reg;
  logic [DW-1:0] en5_reg;
  logic [DW-1:0] set3;
  logic [DW-1:0] set5;
  logic [DW-1:0] clr3;
  logic [DW-1:0] clr5;

  always_comb begin
    set3 = BYTE_ZERO;
    set5 = BYTE_ZERO;
    set3[FLAG_BIT_T4] = t_post[0]; // see (R04)
    set5[FLAG_BIT_T6] = t_post[1]; // see (R04)
    set5[FLAG_BIT_T8] = t_post[2]; // see (R04)
    clr3 = (wr_go && avs_address == OFS_FLAGS3) ? wbyte : BYTE_ZERO;
    clr5 = (wr_go && avs_address == OFS_FLAGS5) ? wbyte : BYTE_ZERO;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags3_reg <= BYTE_ZERO;
      flags5_reg <= BYTE_ZERO;
    end else begin
      flags3_reg <= ((flags3_reg & ~clr3) | set3) & FLAGS3_MASK; // see (R16)
      flags5_reg <= ((flags5_reg & ~clr5) | set5) & FLAGS5_MASK; // see (R16)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en3_reg <= BYTE_ZERO;
      en5_reg <= BYTE_ZERO;
    end else if (wr_go && avs_address == OFS_EN3) begin
      en3_reg <= wbyte & FLAGS3_MASK;
    end else if (wr_go && avs_address == OFS_EN5) begin
      en5_reg <= wbyte & FLAGS5_MASK;
    end
  end

  assign irq = (|(flags3_reg & en3_reg)) | (|(flags5_reg & en5_reg)); // see (R05)

  // ************************************************************
  // PWM time base selection
  // ************************************************************
  logic [5:0] tsel_reg;
  logic [NUM_CH-1:0][DW-1:0] pwm_count_reg;
  logic [NUM_CH-1:0] pwm_match_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tsel_reg <= TSEL_RST;
    end else if (wr_go && avs_address == OFS_TSEL) begin
      tsel_reg <= wbyte[5:0]; // see (R11)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_count_reg <= '0;
      pwm_match_reg <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (int'(tsel_reg[c*SEL_W +: SEL_W]) < NUM_TMR) begin
          pwm_count_reg[c] <= t_count[tsel_reg[c*SEL_W +: SEL_W]]; // see (R10)
          pwm_match_reg[c] <= t_match[tsel_reg[c*SEL_W +: SEL_W]]; // see (R15)
        end else begin
          pwm_count_reg[c] <= BYTE_ZERO;
          pwm_match_reg[c] <= 1'b0;
        end
      end
    end
  end

  assign pwm_count = pwm_count_reg;
  assign pwm_match = pwm_match_reg;

  // ************************************************************
  // Read decode
  // ************************************************************
  always_comb begin
    rd_mux = BYTE_ZERO;
    if (avs_address == OFS_FLAGS3) begin
      rd_mux = flags3_reg;
    end else if (avs_address == OFS_FLAGS5) begin
      rd_mux = flags5_reg;
    end else if (avs_address == OFS_EN3) begin
      rd_mux = en3_reg;
    end else if (avs_address == OFS_EN5) begin
      rd_mux = en5_reg;
    end else if (avs_address == OFS_TSEL) begin
      rd_mux = {2'h0, tsel_reg};
    end else begin
      for (int k = 0; k < NUM_TMR; k++) begin
        if (ptm8_hit(avs_address, k, OFS_COUNT)) begin
          rd_mux = t_count[k]; // see (R01)
        end else if (ptm8_hit(avs_address, k, OFS_PERIOD)) begin
          rd_mux = t_period[k]; // see (R01)
        end else if (ptm8_hit(avs_address, k, OFS_CTRL)) begin
          rd_mux = {1'b0, t_ctrl[k]};
        end
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_flag_t4_set: assert property (t_post[0] |=> flags3_reg[FLAG_BIT_T4]) // see (R04)
    else $error("timer four flag not set");
  chk_flag_t8_set: assert property (t_post[2] |=> flags5_reg[FLAG_BIT_T8]) // see (R04)
    else $error("timer eight flag not set");
  chk_flag_sticky: assert property (flags5_reg[FLAG_BIT_T6] && !clr5[FLAG_BIT_T6]
                                    |=> flags5_reg[FLAG_BIT_T6]) // see (R16)
    else $error("timer six flag dropped without a clear");
  chk_irq_masked: assert property ((flags3_reg & en3_reg) == BYTE_ZERO
                                   && (flags5_reg & en5_reg) == BYTE_ZERO |-> !irq) // see (R05)
    else $error("interrupt raised with no enabled flag");
  chk_irq_raise: assert property (t_post[0] && en3_reg[FLAG_BIT_T4] && !wr_go |=> irq) // see (R05)
    else $error("enabled timer flag did not raise interrupt");
  sequence s_sel_timer0;
    tsel_reg[SEL_W-1:0] == 2'h0;
  endsequence
  chk_tb_route: assert property (s_sel_timer0 ##1 s_sel_timer0
                                 |-> pwm_count[0] == $past(t_count[0])) // see (R11)
    else $error("channel zero not driven by selected timer");
  chk_tb_prepost: assert property (tsel_reg[2*SEL_W-1:SEL_W] == 2'h1
                                   |=> pwm_match[1] == $past(t_match[1])) // see (R15)
    else $error("time base match not taken before postscaler");
  chk_bus_answer: assert property (req && !ack_reg |=> !avs_waitrequest || !req) // see (R01)
    else $error("bus request not answered in one cycle");
endmodule : ptm8_top

/* verif/ptm8_pwm_model.sv */
// Model of the PWM channels that take their time base from the timers
`timescale 1ns/10ps
module ptm8_pwm_model (
  input logic clk,
  input logic resetn,
  input logic [ptm8_pkg::NUM_CH-1:0][ptm8_pkg::DW-1:0] pwm_count,
  input logic [ptm8_pkg::NUM_CH-1:0] pwm_match,
  output logic [ptm8_pkg::NUM_CH-1:0][15:0] hits,
  output logic [ptm8_pkg::NUM_CH-1:0][15:0] gap,
  output logic [15:0] bad
);
  import ptm8_pkg::*;
  logic [NUM_CH-1:0][15:0] age;

  // Period of each channel's time base, measured in clocks between matches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hits <= '0;
      gap <= '0;
      age <= '0;
      bad <= 16'h0000;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (pwm_match[c] === 1'b1) begin
          gap[c] <= age[c] + 16'h0001;
          age[c] <= 16'h0000;
          hits[c] <= hits[c] + 16'h0001;
          if (pwm_count[c] !== BYTE_ZERO) begin
            bad <= bad + 16'h0001;
          end
        end else begin
          age[c] <= age[c] + 16'h0001;
        end
      end
    end
  end
endmodule : ptm8_pwm_model

/* verif/ptm8_top_bench.sv */
// Self-checking bench of the three period match timers
`timescale 1ns/10ps
module ptm8_top_bench;
  import ptm8_pkg::*;
  localparam logic [AW-1:0] FLAG_ADR [3] = '{OFS_FLAGS3, OFS_FLAGS5, OFS_FLAGS5};
  localparam logic [AW-1:0] EN_ADR [3] = '{OFS_EN3, OFS_EN5, OFS_EN5};
  localparam logic [DW-1:0] BIT_M [3] = '{8'h08, 8'h08, 8'h10};
  localparam logic [3:0] PS [3] = '{4'h0, 4'hF, 4'h2};
  localparam int PRE_N [4] = '{1, 4, 16, 16};
  logic clk;
  logic resetn;
  logic [AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [BW-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [BW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [NUM_CH-1:0][DW-1:0] pwm_count;
  logic [NUM_CH-1:0] pwm_match;
  logic [NUM_CH-1:0][15:0] hits;
  logic [NUM_CH-1:0][15:0] gap;
  logic [15:0] bad;
  logic [31:0] q;
  logic [15:0] h0;
  logic [AW-1:0] ba;
  int err_count;
  int check_count;

  ptm8_top dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .pwm_count(pwm_count), .pwm_match(pwm_match));
  ptm8_pwm_model partner (.clk(clk), .resetn(resetn), .pwm_count(pwm_count),
    .pwm_match(pwm_match), .hits(hits), .gap(gap), .bad(bad));

  always #12.5 clk = ~clk;

  task report_and_stop();
    err_count = err_count + int'(bad);
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task fail_wait();
    err_count++;
    $display("Error at %0t: wait timed out", $time);
    report_and_stop();
  endtask : fail_wait

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // ************************************************************
  // Avalon-MM master
  // ************************************************************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    // Values read right after the edge are those that stood at it
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64) begin
      fail_wait();
    end
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, exp});
  endtask : rd_chk

  task automatic wait_hits(input int c, input logic [15:0] target);
    int n;
    n = 0;
    while (hits[c] !== target && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) begin
      fail_wait();
    end
  endtask : wait_hits

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) begin
      fail_wait();
    end
  endtask : wait_irq

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    err_count = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // ************************************************************
    // Reset values and register access
    // ************************************************************
    for (int t = 0; t < NUM_TMR; t++) begin
      ba = TMR_STRIDE * 8'(t);
      rd_chk(ba + OFS_COUNT, 8'h00);
      rd_chk(ba + OFS_PERIOD, 8'hFF);
      rd_chk(ba + OFS_CTRL, 8'h00);
      wr(ba + OFS_PERIOD, 8'h02);
      rd_chk(ba + OFS_PERIOD, 8'h02);
    end
    wr(8'h28, 8'hFF);
    rd_chk(8'h28, 8'h7F);
    wr(8'h28, 8'h00);
    rd_chk(8'h50, 8'h00);
    wr(8'h50, 8'hFF);
    avs_byteenable <= 4'hE;
    wr(OFS_PERIOD, 8'h55);
    avs_byteenable <= 4'hF;
    rd_chk(OFS_PERIOD, 8'h02);
    // ************************************************************
    // Prescaler and PWM time base
    // ************************************************************
    wr(OFS_TSEL, 8'h24);
    for (int k = 0; k < 4; k++) begin
      ba = TMR_STRIDE * 8'(k % 3);
      wr(ba + OFS_CTRL, 8'h04 | 8'(k));
      @(negedge clk);
      h0 = hits[k % 3];
      wait_hits(k % 3, h0 + 16'h0002);
      chk(32'(gap[k % 3]), 32'(12 * PRE_N[k]));
      wr(ba + OFS_CTRL, 8'h00);
    end
    wr(OFS_CTRL, 8'h04);
    wr(OFS_TSEL, 8'h3F);
    // A match registered under the old select still reaches the model
    repeat (2) @(negedge clk);
    h0 = hits[0];
    repeat (40) @(negedge clk);
    chk(32'(hits[0]), 32'(h0));
    chk(32'(pwm_count), 32'h0);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_TSEL, 8'h24);
    // ************************************************************
    // Postscaler, flags and interrupt
    // ************************************************************
    for (int t = 0; t < NUM_TMR; t++) begin
      ba = TMR_STRIDE * 8'(t);
      wr(FLAG_ADR[t], 8'hFF);
      wr(EN_ADR[t], BIT_M[t]);
      @(negedge clk);
      h0 = hits[t];
      wr(ba + OFS_CTRL, 8'h04 | {1'b0, PS[t], 3'b000});
      wait_irq();
      // The model counts the last match one cycle after the flag rises
      @(negedge clk);
      chk(32'(hits[t] - h0), 32'(PS[t]) + 1);
      rd_chk(FLAG_ADR[t], BIT_M[t]);
      wr(FLAG_ADR[t], BIT_M[t]);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      h0 = hits[t];
      wait_irq();
      @(negedge clk);
      chk(32'(hits[t] - h0), 32'(PS[t]) + 1);
      wr(EN_ADR[t], 8'h00);
      wr(FLAG_ADR[t], BIT_M[t]);
      @(negedge clk);
      h0 = hits[t];
      wait_hits(t, h0 + 16'(PS[t]) + 16'h0001);
      repeat (3) @(negedge clk);
      chk(32'(irq), 32'h0);
      rd_chk(FLAG_ADR[t], BIT_M[t]);
      wr(ba + OFS_CTRL, 8'h00);
      wr(FLAG_ADR[t], BIT_M[t]);
    end
    // ************************************************************
    // Run control and control writes keep the count
    // ************************************************************
    wr(8'h14, 8'h40);
    wr(8'h10, 8'h05);
    wr(8'h18, 8'h06);
    rd_chk(8'h10, 8'h05);
    wr(8'h18, 8'h02);
    repeat (100) @(posedge clk);
    rd_chk(8'h10, 8'h05);
    report_and_stop();
  end
endmodule : ptm8_top_bench
